// >>> src/ebt_cycle_term.sv
// ebt_cycle_term: bus master termination engine for external cycles
// assumes: slave handshake pins are asynchronous and active low at the pins;
// the core holds req stable while busy; one system clock, reset async low
// logic runs on the rising edge; a rising edge here stands for the falling
// edge on which the external pins are recognized

// Notes on behaviour
// - address strobe starts cycle; data strobe qualifies writes
// - fault aborts; fault plus stop retries
// - unbounded waits, whole clocks, minimum three
// - ack recognized, data captured next edge
// - early held ack gives three clocks
// - fast termination completes in two clocks
// - ack source chooses internal or external
// - fast cycles strobe data only on reads
// - fast acknowledge is internal only
module ebt_cycle_term (
	input  wire logic                 clock,
	input  wire logic                 resetn,
	// core side
	input  wire logic                 req_valid,
	input  wire ebt_pkg::ebt_req_type req,
	output logic                      req_ready,
	output logic                      done,
	output ebt_pkg::ebt_resp_type     resp,
	// pins toward the slaves (active low where named _n)
	output logic                      address_strobe_n,
	output logic                      data_strobe_n,
	output logic                      read_write,
	output logic [23:0]               addr_out,
	output logic [1:0]                size_out,
	output logic [15:0]               data_out,
	output logic                      data_oe_n,
	input  wire logic [15:0]          data_in,
	input  wire logic                 byte_port_ack_n,
	input  wire logic                 word_port_ack_n,
	input  wire logic                 bus_fault_n,
	input  wire logic                 stop_request_n
);

	// ==========================================================
	// input synchronisers
	// ==========================================================
	ebt_pkg::ebt_term_type sync1_reg;   // first stage, read by stage two only
	ebt_pkg::ebt_term_type sync2_reg;   // usable samples
	logic [15:0]           din1_reg;    // data bus first stage
	logic [15:0]           din2_reg;    // data bus second stage

	// two flops on every pin: costs latency, avoids metastable decisions
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
			din1_reg  <= 16'h0000;
			din2_reg  <= 16'h0000;
		end else begin
			sync1_reg <= {~byte_port_ack_n, ~word_port_ack_n,
			              ~bus_fault_n, ~stop_request_n};
			sync2_reg <= sync1_reg;
			din1_reg  <= data_in;
			din2_reg  <= din1_reg;
		end
	end

	logic ack_seen;   // any port-size acknowledge present
	assign ack_seen = sync2_reg.byte_port_ack | sync2_reg.word_port_ack;

	// ==========================================================
	// cycle state machine
	// ==========================================================
	ebt_pkg::ebt_state_type state_reg,  state_next;
	ebt_pkg::ebt_req_type   cur_reg,    cur_next;    // latched request
	logic [3:0]             wait_reg,   wait_next;   // shared wait counter
	logic [1:0]             psize_reg,  psize_next;  // acked port width
	logic                   fault_reg,  fault_next;  // bus fault seen, in wait or latch
	logic                   retry_reg,  retry_next;  // retry requested
	ebt_pkg::ebt_resp_type  resp_reg,   resp_next;
	logic                   done_reg,   done_next;
	logic                   fast_drain;  // fast cycle, read or write, still draining

	// the synchroniser costs two edges, which a two-clock pin cycle
	// cannot hide; the core waits, the pins are already free
	assign fast_drain = (cur_reg.ack_source == ebt_pkg::ACK_SRC_FAST)
	                  & (wait_reg != 4'h0);

	// next-state logic for the whole cycle
	always_comb begin
		state_next = state_reg;
		cur_next   = cur_reg;
		wait_next  = wait_reg;
		psize_next = psize_reg;
		fault_next = fault_reg;
		retry_next = retry_reg;
		resp_next  = resp_reg;
		done_next  = 1'b0;
		unique case (state_reg)
			ebt_pkg::ST_IDLE: begin
				// new cycle; address strobe marks its start
				if (req_valid) begin
					cur_next   = req;
					wait_next  = req.wait_count;
					fault_next = 1'b0;
					retry_next = 1'b0;
					state_next = ebt_pkg::ST_ADDR;
				end
			end
			ebt_pkg::ST_ADDR: begin
				// fast termination: internal ack, no pin sampled
				if (cur_reg.ack_source == ebt_pkg::ACK_SRC_FAST) begin
					psize_next = 2'h2;
					wait_next  = ebt_pkg::FAST_DRAIN;
					state_next = ebt_pkg::ST_END;
				end else begin
					state_next = ebt_pkg::ST_WAIT;
				end
			end
			ebt_pkg::ST_WAIT: begin
				// fault alone aborts, fault with stop retries
				if (sync2_reg.bus_fault) begin
					fault_next = 1'b1;
					retry_next = sync2_reg.stop_request;
					state_next = ebt_pkg::ST_END;
				end else if (cur_reg.ack_source == ebt_pkg::ACK_SRC_WAIT) begin
					// internal ack after the shared count expires
					if (wait_reg == 4'h0) begin
						psize_next = 2'h2;
						state_next = ebt_pkg::ST_LATCH;
					end else begin
						wait_next = wait_reg - 4'h1;
					end
				end else if (ack_seen) begin
					// port width taken from which ack stands alone
					psize_next = {sync2_reg.word_port_ack,
					              sync2_reg.byte_port_ack};
					state_next = ebt_pkg::ST_LATCH;
				end
				// otherwise stay: one whole-clock wait, no limit
			end
			ebt_pkg::ST_LATCH: begin
				// data taken one edge after ack recognition
				resp_next.rdata = din2_reg;
				// a late fault one clock after the ack still counts
				if (sync2_reg.bus_fault) begin
					fault_next = 1'b1;
					retry_next = sync2_reg.stop_request;
				end
				state_next = ebt_pkg::ST_END;
			end
			ebt_pkg::ST_END: begin
				// strobes are off; a fast read waits here while the value
				// sampled in its second clock crosses both input flops
				if (fast_drain) begin
					wait_next = wait_reg - 4'h1;
				end else if (retry_reg) begin
					state_next = ebt_pkg::ST_RETRY;
				end else begin
					if (cur_reg.ack_source == ebt_pkg::ACK_SRC_FAST) begin
						resp_next.rdata = din2_reg;
					end
					resp_next.port_size = psize_reg;
					resp_next.fault     = fault_reg;
					done_next           = 1'b1;
					state_next          = ebt_pkg::ST_IDLE;
				end
			end
			ebt_pkg::ST_RETRY: begin
				// rerun the same request once stop-request falls
				if (!sync2_reg.stop_request) begin
					wait_next  = cur_reg.wait_count;
					fault_next = 1'b0;
					retry_next = 1'b0;
					state_next = ebt_pkg::ST_ADDR;
				end
			end
			default: begin
				state_next = ebt_pkg::ST_IDLE;
			end
		endcase
	end

	// state registers
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			state_reg <= ebt_pkg::ST_IDLE;
			cur_reg   <= '0;
			wait_reg  <= 4'h0;
			psize_reg <= 2'h0;
			fault_reg <= 1'b0;
			retry_reg <= 1'b0;
			resp_reg  <= '0;
			done_reg  <= 1'b0;
		end else begin
			state_reg <= state_next;
			cur_reg   <= cur_next;
			wait_reg  <= wait_next;
			psize_reg <= psize_next;
			fault_reg <= fault_next;
			retry_reg <= retry_next;
			resp_reg  <= resp_next;
			done_reg  <= done_next;
		end
	end

	// ==========================================================
	// pin drivers
	// ==========================================================
	logic as_next, ds_next;   // strobe values for the coming cycle
	logic as_reg,  ds_reg;    // registered, active high internally

	// address strobe covers every active state; end state drops both strobes
	always_comb begin
		as_next = (state_next == ebt_pkg::ST_ADDR)
		        | (state_next == ebt_pkg::ST_WAIT)
		        | (state_next == ebt_pkg::ST_LATCH);
		// reads strobe at once, writes when data is stable
		ds_next = as_next & (cur_next.read
		        | (state_next != ebt_pkg::ST_ADDR));
		// fast cycles never strobe data on writes
		if (cur_next.ack_source == ebt_pkg::ACK_SRC_FAST
		    && !cur_next.read) begin
			ds_next = 1'b0;
		end
		// fast cycle: two clocks, strobes only in the address state
		if (cur_next.ack_source == ebt_pkg::ACK_SRC_FAST
		    && state_next == ebt_pkg::ST_ADDR && cur_next.read) begin
			ds_next = 1'b1;
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			as_reg <= 1'b0;
			ds_reg <= 1'b0;
		end else begin
			as_reg <= as_next;
			ds_reg <= ds_next;
		end
	end

	// address, size, direction hold through the end state
	assign address_strobe_n = ~as_reg;
	assign data_strobe_n    = ~ds_reg;
	assign read_write       = cur_reg.read;
	assign addr_out         = cur_reg.addr;
	assign size_out         = cur_reg.size;
	assign data_out         = cur_reg.wdata;
	assign data_oe_n        = ~((state_reg != ebt_pkg::ST_IDLE)
	                          & (state_reg != ebt_pkg::ST_RETRY)
	                          & ~cur_reg.read);
	assign req_ready        = (state_reg == ebt_pkg::ST_IDLE);
	assign done             = done_reg;
	assign resp             = resp_reg;

endmodule : ebt_cycle_term

// >>> src/ebt_pkg.sv
// ebt_pkg: shared types and constants for the external bus termination block
// assumes: one system clock; handshake pins are sampled by the core module
package ebt_pkg;

	// ==========================================================
	// cycle timing
	// ==========================================================
	localparam int unsigned MIN_ACK_CYCLES  = 3; // shortest acked cycle
	localparam int unsigned FAST_CYCLES     = 2; // fast-termination cycle
	localparam int unsigned WAIT_CNT_W      = 4; // shared wait counter width
	// extra edges a fast read spends so its data clears both input flops
	localparam logic [3:0]  FAST_DRAIN      = 4'h2;

	// acknowledge-source encodings
	localparam logic [1:0]  ACK_SRC_EXT     = 2'h0; // external acknowledge
	localparam logic [1:0]  ACK_SRC_WAIT    = 2'h1; // internal after waits
	localparam logic [1:0]  ACK_SRC_FAST    = 2'h2; // internal, two clocks

	// termination outcome codes
	localparam logic [1:0]  RES_OK          = 2'h0;
	localparam logic [1:0]  RES_FAULT       = 2'h1;

	// ==========================================================
	// carriers
	// ==========================================================
	// one bus request from the core side
	typedef struct packed {
		logic [23:0] addr;          // byte address
		logic [1:0]  size;          // transfer size hi/lo
		logic        read;          // 1 = read, 0 = write
		logic [15:0] wdata;         // write data
		logic [1:0]  ack_source;    // ack_source_field of matched select
		logic [3:0]  wait_count;    // internal waits for ACK_SRC_WAIT
	} ebt_req_type;

	// raw external termination inputs, active high after inversion
	typedef struct packed {
		logic byte_port_ack;
		logic word_port_ack;
		logic bus_fault;
		logic stop_request;
	} ebt_term_type;

	// result handed back to the core
	typedef struct packed {
		logic [15:0] rdata;         // captured read data
		logic [1:0]  port_size;     // {word_port_ack, byte_port_ack}
		logic        fault;         // cycle aborted by bus fault
	} ebt_resp_type;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_WAIT,
		ST_LATCH,
		ST_END,
		ST_RETRY
	} ebt_state_type;

endpackage : ebt_pkg

// >>> tb/ebt_cycle_term_monitor.sv
// ebt_cycle_term_monitor: pin timing checks on the termination engine
// assumes: bound onto ebt_cycle_term; req stays stable up to done
module ebt_cycle_term_monitor (
	input wire logic                 clock,
	input wire logic                 resetn,
	input wire logic                 req_valid,
	input wire ebt_pkg::ebt_req_type req,
	input wire logic                 req_ready,
	input wire logic                 done,
	input wire ebt_pkg::ebt_resp_type resp,
	input wire logic                 address_strobe_n,
	input wire logic                 data_strobe_n,
	input wire logic                 read_write,
	input wire logic                 word_port_ack_n,
	input wire logic                 bus_fault_n,
	input wire logic                 stop_request_n
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);
	logic take; // request accepted this edge
	logic fast; // internal two-clock source
	logic ext;  // external acknowledge source
	assign take = req_valid && req_ready;
	assign fast = req.ack_source == ebt_pkg::ACK_SRC_FAST;
	assign ext  = req.ack_source == ebt_pkg::ACK_SRC_EXT;
	a_strobe_start: assert property (take |=> !address_strobe_n)
		else $error("no strobe after take");
	a_min_three: assert property ($fell(address_strobe_n) && !fast
		|-> !done [*3]) else $error("cycle too short");
	a_fast_two: assert property (take && fast |-> ##5 done)
		else $error("fast cycle length");
	a_wait_zero: assert property (take && !fast && !ext
		&& req.wait_count == 4'h0 |-> ##5 done) else $error("wait length");
	a_fast_nods: assert property (!address_strobe_n && fast
		&& !read_write |-> data_strobe_n) else $error("strobe on write");
	a_ack_done: assert property (!address_strobe_n && ext
		&& !word_port_ack_n && bus_fault_n |-> ##[1:8] done)
		else $error("ack not honoured");
	a_end_release: assert property (done |-> address_strobe_n
		&& data_strobe_n) else $error("strobes held at done");
	a_retry_hold: assert property (!stop_request_n [*8]
		|-> address_strobe_n) else $error("rerun during stop");
	// main scenarios reached
	c_fast:  cover property (take && fast);
	c_fault: cover property (done && resp.fault);
	c_retry: cover property (!stop_request_n && !bus_fault_n);
endmodule : ebt_cycle_term_monitor

// >>> tb/ebt_slave_model.sv
// ebt_slave_model: memory slave answering after a set delay
// assumes: mode and delay held by the bench for the whole cycle
module ebt_slave_model (
	input  wire logic        clock,
	input  wire logic        address_strobe_n,
	input  wire logic [23:0] addr_out,
	input  wire logic [1:0]  size_out,
	input  wire logic [15:0] data_out,
	input  wire logic [2:0]  mode,  // 0 byte,1 word,2 fault,3 retry,4 mute,
	                                // 5 word ack then late fault
	input  wire logic [3:0]  delay, // edges from strobe to answer
	output logic [15:0]      data_in,
	output logic [15:0]      wr_seen,
	output logic             byte_port_ack_n,
	output logic             word_port_ack_n,
	output logic             bus_fault_n,
	output logic             stop_request_n
);
	timeunit 1ns;
	timeprecision 100ps;
	// one-byte size code as this bench drives it; arbitrary bench choice
	localparam logic [1:0] BYTE_CODE = 2'h1;
	int          cnt;     // edges since strobe fell
	int          scnt;    // edges of stop held
	logic        retried; // rerun answers with a word ack
	logic [1:0]  lane;    // byte-lane strobes {upper, lower}
	logic [15:0] wr_lane; // write data merged by lane
	// size and a0 pick the active half of the bus
	assign lane    = (size_out == BYTE_CODE) ? {~addr_out[0], addr_out[0]}
	                                         : 2'h3;
	assign wr_lane = {lane[1] ? data_out[15:8] : wr_seen[15:8],
	                  lane[0] ? data_out[7:0]  : wr_seen[7:0]};
	initial begin
		{byte_port_ack_n, word_port_ack_n, bus_fault_n, stop_request_n} = 4'hF;
		{cnt, scnt, retried, data_in, wr_seen} = '0;
	end
	// slave answers in step with the system clock
	always @(posedge clock) begin
		scnt <= stop_request_n ? 0 : scnt + 1;
		if (scnt == 12) stop_request_n <= 1'b1;
		if (address_strobe_n) begin
			// release within a clock of strobe negation
			{byte_port_ack_n, word_port_ack_n, bus_fault_n} <= 3'h7;
			data_in <= ~data_in; // released bus wanders
			cnt <= 0;
		end else begin
			cnt <= cnt + 1;
			data_in <= addr_out[15:0] ^ 16'h5A5A;
			if (cnt == delay) begin
				case (retried ? 3'h1 : mode)
					3'h0: {byte_port_ack_n, wr_seen} <= {1'b0, wr_lane};
					3'h1, 3'h5: {word_port_ack_n, wr_seen, retried}
					            <= {1'b0, wr_lane, 1'b0};
					3'h2: bus_fault_n <= 1'b0;
					3'h3: {bus_fault_n, stop_request_n, retried} <= 3'h1;
					// fast cycles: no external ack; the select follows the
					// address strobe, so writes latch on it
					default: wr_seen <= wr_lane;
				endcase
			end
			// late fault one edge after the ack, inside the bound
			if (mode == 3'h5 && cnt == int'(delay) + 1) bus_fault_n <= 1'b0;
		end
	end
endmodule : ebt_slave_model

// >>> tb/ebt_cycle_term_test.sv
// ebt_cycle_term_test: directed cycles against the slave model
// assumes: one clock at 200 MHz, asynchronous active-low reset
module ebt_cycle_term_test;
	timeunit 1ns;
	timeprecision 100ps;
	logic clock = 1'b0, resetn = 1'b0, req_valid = 1'b0, req_ready, done;
	logic as_n, ds_n, rw, oe_n, b_n, w_n, f_n, s_n;
	logic [23:0] ao;
	logic [1:0] sz;
	logic [15:0] dout, din, wr_seen;
	logic [2:0] mode = 3'h4;
	logic [3:0] delay = 4'h0;
	ebt_pkg::ebt_req_type req = '0;
	ebt_pkg::ebt_resp_type resp;
	int errors = 0, tests_run = 0, n, n0;
	always #2.5 clock = ~clock;
	ebt_cycle_term DUT (.clock, .resetn, .req_valid, .req, .req_ready, .done,
		.resp, .address_strobe_n(as_n), .data_strobe_n(ds_n), .read_write(rw),
		.addr_out(ao), .size_out(sz), .data_out(dout), .data_oe_n(oe_n),
		.data_in(din), .byte_port_ack_n(b_n), .word_port_ack_n(w_n),
		.bus_fault_n(f_n), .stop_request_n(s_n));
	ebt_slave_model u_slave (.clock, .address_strobe_n(as_n), .addr_out(ao),
		.size_out(sz),
		.data_out(dout), .mode, .delay, .data_in(din), .wr_seen,
		.byte_port_ack_n(b_n), .word_port_ack_n(w_n), .bus_fault_n(f_n),
		.stop_request_n(s_n));
	task automatic check(input logic ok, input string msg);
		tests_run++;
		if (ok !== 1'b1) begin
			errors++;
			$display("CHECK FAILED %0t %s", $time, msg);
		end
	endtask : check
	// one bus cycle; n counts edges from take to done
	task automatic xfer(input logic [1:0] src, input logic rd,
		input logic [3:0] wc, input logic [15:0] wd);
		@(posedge clock);
		req <= '{24'h00_1234 + wd, 2'h2, rd, wd, src, wc};
		req_valid <= 1'b1;
		@(posedge clock);
		req_valid <= 1'b0;
		n = 0;
		do begin
			@(posedge clock);
			#1 n++;
		end while (done !== 1'b1 && n < 100);
	endtask : xfer
	task automatic conclude;
		$display("errors %0d tests_run %0d", errors, tests_run);
		if (errors == 0 && tests_run > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : conclude
	initial begin
		#20000 errors++;
		conclude();
	end
	initial begin
		repeat (6) @(posedge clock);
		resetn <= 1'b1;
		// two clocks on the pins, two more while read data crosses the flops
		xfer(ebt_pkg::ACK_SRC_FAST, 1'b1, 4'h0, 16'h0010);
		check(n == 4, "fast read length");
		check(resp.rdata === (16'h1244 ^ 16'h5A5A), "fast data");
		check(resp.port_size === 2'h2, "fast size");
		xfer(ebt_pkg::ACK_SRC_FAST, 1'b0, 4'h0, 16'h0020);
		check(n == 4, "fast write length");
		check(wr_seen === 16'h0020, "fast write data");
		for (int w = 0; w < 8; w += 7) begin
			xfer(ebt_pkg::ACK_SRC_WAIT, 1'b1, w[3:0], 16'h0030);
			check(n == w + 4, "wait count length");
		end
		mode = 3'h0;
		xfer(ebt_pkg::ACK_SRC_EXT, 1'b1, 4'h0, 16'h0040);
		n0 = n;
		// ack one edge after the strobe, two sync edges, latch, end, done
		check(n0 == 6 && resp.port_size === 2'h1, "byte ack");
		check(sz === 2'h2, "size pins");
		check(resp.rdata === (16'h1274 ^ 16'h5A5A), "ext data");
		{mode, delay} = {3'h1, 4'h9};
		xfer(ebt_pkg::ACK_SRC_EXT, 1'b1, 4'h0, 16'h0050);
		check(n == n0 + 9 && resp.port_size === 2'h2, "waits");
		{mode, delay} = {3'h0, 4'h2};
		xfer(ebt_pkg::ACK_SRC_EXT, 1'b0, 4'h0, 16'hC3A6);
		check(wr_seen === 16'hC3A6, "write data");
		mode = 3'h2;
		xfer(ebt_pkg::ACK_SRC_EXT, 1'b1, 4'h0, 16'h0060);
		check(resp.fault === 1'b1, "abort");
		{mode, delay} = {3'h5, 4'h0};
		xfer(ebt_pkg::ACK_SRC_EXT, 1'b1, 4'h0, 16'h0080);
		check(n == 6 && resp.fault === 1'b1, "late fault");
		{mode, delay} = {3'h3, 4'h0};
		xfer(ebt_pkg::ACK_SRC_EXT, 1'b1, 4'h0, 16'h0070);
		check(n > 12 && resp.fault === 1'b0, "retry");
		check(resp.rdata === (16'h12A4 ^ 16'h5A5A), "rerun data");
		conclude();
	end
endmodule : ebt_cycle_term_test
bind ebt_cycle_term ebt_cycle_term_monitor u_mon (.clock, .resetn,
	.req_valid, .req, .req_ready, .done, .resp, .address_strobe_n,
	.data_strobe_n, .read_write, .word_port_ack_n, .bus_fault_n,
	.stop_request_n);
